// file: design/fsg_pkg.sv
/*
  Constants, types and helpers for the fieldbus serial gateway framer.
  Assumes one 50 MHz clock and a 32-bit APB master on the register side.
*/
// Summary of operation
// - Host telegrams carry two control bytes in, two status bytes out.
// - User data starts at the third byte in both directions.
// - Control bits live in the output image, status bits in the input image.
// - In transparent mode, serial data longer than host length is truncated and data loss is flagged.
// - Control byte 0: command mode, broadcast, five-bit address, host new-data flag.
// - Serial side gets only data, wrapped in start and two stop bytes.
// - Both control bytes are consumed inside the gateway.
// - Status byte 0 bit 2 shows service mode.
// - Status byte 0 bit 7 is new-data toggle; bits 0,1,3,4,6 reserved.
// - Status byte 1 is the count of user bytes that follow.
// - A toggle flag inverts on every qualifying event.
// - Transparent and collective forwarding modes, selection readable.
// - Collective mode buffers serial data in a 1024-byte ring, fill readable.
// - Command mode queues host commands in a 1024-byte ring, fill readable.
// - Count framing-error characters and complete received serial frames.
// - Count host commands rejected as invalid.
// - Count serial frames the transmit path failed to send.
// - Count plain serial frames sent and telegrams sent to the host.
// - Only baud follows the device select switch (position 8); start, stop bytes and framing are fixed.
// - Flag that a valid serial configuration was accepted after start-up.
// - New-data and data-loss flags are readable.
// - In transparent mode the new-data flag inverts for every data set sent to the host.
// - Service flag set in either service position, cleared in run.
// - Command mode bit 0 stops forwarding host data to serial.
package fsg_pkg;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_MHZ       = 50;
	localparam int TX_TIMEOUT_US = 10000;
	localparam int TX_TIMEOUT_CYC = TX_TIMEOUT_US * CLK_MHZ;
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// -----------------------------------------------------------------
	// Buffers and counters
	// -----------------------------------------------------------------
	localparam logic [10:0] RING_DEPTH = 11'h400;
	localparam int NCNT      = 8;
	localparam int CNT_RXF   = 0;
	localparam int CNT_FERR  = 1;
	localparam int CNT_TYPEA = 2;
	localparam int CNT_TYPEB = 3;
	localparam int CNT_INVAL = 4;
	localparam int CNT_TXERR = 5;
	localparam int CNT_TXSER = 6;
	localparam int CNT_TXHST = 7;

	// -----------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_HLEN   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SERCFG = 8'h0C;
	localparam logic [7:0] OFS_FILL   = 8'h10;
	localparam logic [7:0] OFS_CNT0   = 8'h14;
	localparam logic [7:0] OFS_CNTN   = 8'h30;
	localparam logic [7:0] HLEN_RST   = 8'h08;

	// -----------------------------------------------------------------
	// Header fields and command codes
	// -----------------------------------------------------------------
	localparam int CB0_CMD  = 0;
	localparam int SB0_SVC  = 2;
	localparam int SB0_LOSS = 5;
	localparam int SB0_ND   = 7;
	localparam logic [7:0] CMD_TYPE_A = 8'h43;
	localparam logic [7:0] CMD_TYPE_B = 8'h46;
	localparam logic [3:0] SEL_MAX_VALID = 4'hC;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {R_HUNT = 2'b00, R_DATA = 2'b01, R_STOP2 = 2'b10} fsg_rx_t;
	typedef enum logic [1:0] {E_IDLE = 2'b00, E_STAT0 = 2'b01, E_BODY = 2'b10} fsg_em_t;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_DATA = 3'b001, T_STOP1 = 3'b010, T_STOP2 = 3'b011
	} fsg_tx_t;

	typedef struct packed {
		logic [7:0] start;
		logic [7:0] stop1;
		logic [7:0] stop2;
		logic [3:0] baud;
		logic [3:0] framing;
	} fsg_ser_cfg_t;

	// Frame characters and line codes per switch position; defaults are neutral
	function automatic fsg_ser_cfg_t ser_cfg(input logic [3:0] sel);
		fsg_ser_cfg_t c;
		c = '{start: 8'h02, stop1: 8'h0D, stop2: 8'h0A, baud: 4'h0, framing: 4'h0};
		if (sel == 4'h8) begin
			c.baud = 4'h1;
		end
		return c;
	endfunction

endpackage

// file: design/fsg_framer.sv
/*
  Gateway framer: host telegram stream in and out, serial byte stream in
  and out, APB register slave. Assumes byte streams and APB run on REF_CLK;
  switch pins are asynchronous and are synchronised here.
*/
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module fsg_framer #(
	parameter int TX_TIMEOUT = fsg_pkg::TX_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output var  logic        PREADY,
	output var  logic        PSLVERR,
	// Switch pins
	input  wire logic [3:0]  DEVICE_SELECT_SWITCH,
	input  wire logic        GATEWAY_SERVICE_POSITION,
	input  wire logic        END_DEVICE_SERVICE_POSITION,
	// Host output image, PLC to gateway
	input  wire logic        HOUT_VALID,
	input  wire logic [7:0]  HOUT_DATA,
	input  wire logic        HOUT_LAST,
	output var  logic        HOUT_READY,
	// Host input image, gateway to PLC
	output var  logic        HIN_VALID,
	output var  logic [7:0]  HIN_DATA,
	output var  logic        HIN_LAST,
	input  wire logic        HIN_READY,
	// Serial receive
	input  wire logic        SRX_VALID,
	input  wire logic [7:0]  SRX_DATA,
	input  wire logic        SRX_FERR,
	// Serial transmit
	output var  logic        STX_VALID,
	output var  logic [7:0]  STX_DATA,
	input  wire logic        STX_READY
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                prdy;
		logic [31:0]         prdata;
		logic                pslverr;
		logic                mode_coll;
		logic [7:0]          hlen;
		logic [3:0]          sw_s1, sw_s2;
		logic                sg_s1, sg_s2, sd_s1, sd_s2;
		logic [1:0]          ws_cnt;
		logic                cfg_done, cfg_valid;
		logic [3:0]          sel;
		fsg_pkg::fsg_ser_cfg_t cfg;
		logic                svc;
		logic [1:0]          h_idx;
		logic [7:0]          h_ctrl0;
		logic                hout_rdy;
		logic                hold_v, hold_last, tx_endin, tx_drop;
		logic [7:0]          hold_b;
		fsg_pkg::fsg_tx_t    tst;
		logic                stx_v;
		logic [7:0]          stx_d;
		logic [19:0]         to_cnt;
		fsg_pkg::fsg_rx_t    rst;
		logic [10:0]         rx_wr, rx_com, rx_rd, cmd_wr, cmd_rd;
		fsg_pkg::fsg_em_t    est;
		logic                hin_v, hin_last;
		logic [7:0]          hin_d, e_left;
		logic [10:0]         e_end;
		logic                nd, dl, lost;
		logic [fsg_pkg::NCNT-1:0][15:0] cnt;
	} fsg_state_t;

	localparam logic [19:0] TO_LAST = 20'(TX_TIMEOUT - 1);

	fsg_state_t  q, n;
	logic [7:0]  rx_mem  [1024];
	logic [7:0]  cmd_mem [1024];
	logic        rx_we, cmd_we, loss, trunc, acc;
	logic [10:0] avail, rx_fill, cmd_fill;
	logic [7:0]  elen, cbyte, cidx;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		n       = q;
		rx_we   = 1'b0;
		cmd_we  = 1'b0;
		loss    = 1'b0;
		trunc   = 1'b0;
		elen    = 8'h00;
		cbyte   = cmd_mem[q.cmd_rd[9:0]];
		cidx    = PADDR - fsg_pkg::OFS_CNT0;
		avail   = q.rx_com - q.rx_rd;
		rx_fill = q.rx_wr - q.rx_rd;
		acc     = PSEL && PENABLE && !q.prdy;

		// Pin synchronisers and strap capture after release
		n.sw_s1 = DEVICE_SELECT_SWITCH;
		n.sw_s2 = q.sw_s1;
		n.sg_s1 = GATEWAY_SERVICE_POSITION;
		n.sg_s2 = q.sg_s1;
		n.sd_s1 = END_DEVICE_SERVICE_POSITION;
		n.sd_s2 = q.sd_s1;
		n.svc   = q.sg_s2 | q.sd_s2;
		if (!q.cfg_done) begin
			n.ws_cnt = q.ws_cnt + 2'h1;
			if (q.ws_cnt == fsg_pkg::STRAP_WAIT) begin
				// Switch read once only; moving it later needs a restart
				n.sel       = q.sw_s2;
				n.cfg       = fsg_pkg::ser_cfg(q.sw_s2);
				n.cfg_valid = q.sw_s2 <= fsg_pkg::SEL_MAX_VALID;
				n.cfg_done  = 1'b1;
			end
		end

		// APB slave, one wait state
		n.prdy    = acc;
		n.pslverr = 1'b0;
		if (acc) begin
			n.prdata  = 32'h0000_0000;
			n.pslverr = 1'b1;
			case (PADDR)
				fsg_pkg::OFS_CTRL: begin
					n.pslverr = 1'b0;
					n.prdata  = {31'h0, q.mode_coll};
					if (PWRITE) begin
						n.mode_coll = PWDATA[0];
					end
				end
				fsg_pkg::OFS_HLEN: begin
					n.pslverr = 1'b0;
					n.prdata  = {24'h0, q.hlen};
					if (PWRITE && PWDATA[7:0] != 8'h00) begin
						n.hlen = PWDATA[7:0];
					end
				end
				fsg_pkg::OFS_STATUS: begin
					n.pslverr = PWRITE;
					n.prdata  = {8'h0, q.h_ctrl0, 4'h0, q.sel, 2'h0, q.cfg_done,
						q.mode_coll, q.cfg_valid, q.svc, q.dl, q.nd};
				end
				fsg_pkg::OFS_SERCFG: begin
					n.pslverr = PWRITE;
					n.prdata  = q.cfg;
				end
				fsg_pkg::OFS_FILL: begin
					n.pslverr = PWRITE;
					n.prdata  = {5'h0, q.cmd_wr - q.cmd_rd, 5'h0, rx_fill};
				end
				default: begin
					if (PADDR >= fsg_pkg::OFS_CNT0 && PADDR <= fsg_pkg::OFS_CNTN
						&& PADDR[1:0] == 2'h0) begin
						n.pslverr = PWRITE;
						n.prdata  = {16'h0, q.cnt[cidx[4:2]]};
					end
				end
			endcase
		end

		// Serial receive framing
		if (SRX_VALID && q.cfg_done) begin
			if (SRX_FERR) begin
				n.cnt[fsg_pkg::CNT_FERR] = q.cnt[fsg_pkg::CNT_FERR] + 16'h0001;
				n.rx_wr = q.rx_com;
				n.rst   = fsg_pkg::R_HUNT;
			end else begin
				case (q.rst)
					fsg_pkg::R_HUNT: begin
						if (SRX_DATA == q.cfg.start) begin
							n.rst = fsg_pkg::R_DATA;
						end
					end
					fsg_pkg::R_DATA: begin
						if (SRX_DATA == q.cfg.stop1) begin
							n.rst = fsg_pkg::R_STOP2;
						end else if (rx_fill == fsg_pkg::RING_DEPTH
							|| (!q.mode_coll && q.rx_com != q.rx_rd)) begin
							loss = 1'b1;
						end else begin
							rx_we   = 1'b1;
							n.rx_wr = q.rx_wr + 11'h001;
						end
					end
					fsg_pkg::R_STOP2: begin
						n.rst = fsg_pkg::R_HUNT;
						if (SRX_DATA == q.cfg.stop2) begin
							n.rx_com = q.rx_wr;
							n.cnt[fsg_pkg::CNT_RXF] = q.cnt[fsg_pkg::CNT_RXF] + 16'h0001;
						end else begin
							n.rx_wr = q.rx_com;
						end
					end
					default: n.rst = fsg_pkg::R_HUNT;
				endcase
			end
		end

		// Host telegram out: status 0, length, then data
		case (q.est)
			fsg_pkg::E_IDLE: begin
				if (avail != 11'h000 && q.cfg_done) begin
					trunc    = !q.mode_coll && avail > {3'h0, q.hlen};
					elen     = (avail > {3'h0, q.hlen}) ? q.hlen : avail[7:0];
					n.e_left = elen;
					// Transparent drops the tail; collective keeps it for later
					n.e_end  = q.mode_coll ? q.rx_rd + {3'h0, elen} : q.rx_com;
					n.nd     = q.mode_coll ? q.nd : !q.nd;
					n.dl     = trunc | q.lost | loss;
					n.lost   = 1'b0;
					n.hin_v  = 1'b1;
					n.hin_last = 1'b0;
					n.hin_d  = 8'h00;
					n.hin_d[fsg_pkg::SB0_ND]   = n.nd;
					n.hin_d[fsg_pkg::SB0_LOSS] = n.dl;
					n.hin_d[fsg_pkg::SB0_SVC]  = q.svc;
					n.est    = fsg_pkg::E_STAT0;
				end
			end
			fsg_pkg::E_STAT0: begin
				if (HIN_READY) begin
					n.hin_d    = q.e_left;
					n.hin_last = q.e_left == 8'h00;
					n.est      = fsg_pkg::E_BODY;
				end
			end
			fsg_pkg::E_BODY: begin
				if (HIN_READY) begin
					if (q.hin_last) begin
						n.hin_v    = 1'b0;
						n.hin_last = 1'b0;
						n.rx_rd    = q.e_end;
						n.est      = fsg_pkg::E_IDLE;
						n.cnt[fsg_pkg::CNT_TXHST] = q.cnt[fsg_pkg::CNT_TXHST] + 16'h0001;
					end else begin
						n.hin_d    = rx_mem[q.rx_rd[9:0]];
						n.rx_rd    = q.rx_rd + 11'h001;
						n.e_left   = q.e_left - 8'h01;
						n.hin_last = q.e_left == 8'h01;
					end
				end
			end
			default: n.est = fsg_pkg::E_IDLE;
		endcase
		if (loss) begin
			n.dl   = 1'b1;
			n.lost = 1'b1;
		end

		// Serial transmit: start byte, data, two stop bytes
		case (q.tst)
			fsg_pkg::T_IDLE: begin
				if (q.hold_v) begin
					n.stx_v    = 1'b1;
					n.stx_d    = q.cfg.start;
					n.tx_endin = 1'b0;
					n.tst      = fsg_pkg::T_DATA;
				end
			end
			fsg_pkg::T_DATA: begin
				if (!q.stx_v || STX_READY) begin
					if (q.tx_endin) begin
						n.stx_v = 1'b1;
						n.stx_d = q.cfg.stop1;
						n.tst   = fsg_pkg::T_STOP1;
					end else if (q.hold_v) begin
						n.stx_v    = 1'b1;
						n.stx_d    = q.hold_b;
						n.hold_v   = 1'b0;
						n.tx_endin = q.hold_last;
					end else begin
						n.stx_v = 1'b0;
					end
				end
			end
			fsg_pkg::T_STOP1: begin
				if (STX_READY) begin
					n.stx_d = q.cfg.stop2;
					n.tst   = fsg_pkg::T_STOP2;
				end
			end
			fsg_pkg::T_STOP2: begin
				if (STX_READY) begin
					n.stx_v = 1'b0;
					n.tst   = fsg_pkg::T_IDLE;
					n.cnt[fsg_pkg::CNT_TXSER] = q.cnt[fsg_pkg::CNT_TXSER] + 16'h0001;
				end
			end
			default: n.tst = fsg_pkg::T_IDLE;
		endcase
		// A stuck serial sink aborts the frame rather than stall the host forever
		n.to_cnt = (q.stx_v && !STX_READY) ? q.to_cnt + 20'h00001 : 20'h00000;
		if (q.stx_v && !STX_READY && q.to_cnt == TO_LAST) begin
			n.stx_v   = 1'b0;
			n.hold_v  = 1'b0;
			// Drop the rest of a host telegram only if some of its data is lost
			n.tx_drop = q.h_idx != 2'h0 && (!q.tx_endin || q.hold_v);
			n.tst     = fsg_pkg::T_IDLE;
			n.cnt[fsg_pkg::CNT_TXERR] = q.cnt[fsg_pkg::CNT_TXERR] + 16'h0001;
		end

		// Host telegram in: control bytes consumed, data routed by mode
		if (HOUT_VALID && q.hout_rdy) begin
			case (q.h_idx)
				2'h0: begin
					n.h_ctrl0 = HOUT_DATA;
					n.h_idx   = 2'h1;
				end
				2'h1: n.h_idx = 2'h2;
				default: begin
					if (q.h_ctrl0[fsg_pkg::CB0_CMD]) begin
						cmd_we   = 1'b1;
						n.cmd_wr = q.cmd_wr + 11'h001;
					end else if (!n.tx_drop) begin
						n.hold_v    = 1'b1;
						n.hold_b    = HOUT_DATA;
						n.hold_last = HOUT_LAST;
					end
				end
			endcase
			if (HOUT_LAST) begin
				n.h_idx   = 2'h0;
				n.tx_drop = 1'b0;
			end
		end

		// Command queue drain, one byte per cycle
		if (q.cmd_wr != q.cmd_rd) begin
			n.cmd_rd = q.cmd_rd + 11'h001;
			if (cbyte == fsg_pkg::CMD_TYPE_A) begin
				n.cnt[fsg_pkg::CNT_TYPEA] = q.cnt[fsg_pkg::CNT_TYPEA] + 16'h0001;
			end else if (cbyte == fsg_pkg::CMD_TYPE_B) begin
				n.cnt[fsg_pkg::CNT_TYPEB] = q.cnt[fsg_pkg::CNT_TYPEB] + 16'h0001;
			end else begin
				n.cnt[fsg_pkg::CNT_INVAL] = q.cnt[fsg_pkg::CNT_INVAL] + 16'h0001;
			end
		end
		cmd_fill   = n.cmd_wr - n.cmd_rd;
		n.hout_rdy = q.cfg_done && !n.hold_v && cmd_fill != fsg_pkg::RING_DEPTH;
	end

	// ---------------------------------------------------------------
	// Registers and ring memories
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			q      <= '0;
			q.hlen <= fsg_pkg::HLEN_RST;
		end else begin
			q <= n;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (rx_we) begin
			rx_mem[q.rx_wr[9:0]] <= SRX_DATA;
		end
		if (cmd_we) begin
			cmd_mem[q.cmd_wr[9:0]] <= HOUT_DATA;
		end
	end

	assign PRDATA     = q.prdata;
	assign PREADY     = q.prdy;
	assign PSLVERR    = q.pslverr;
	assign HOUT_READY = q.hout_rdy;
	assign HIN_VALID  = q.hin_v;
	assign HIN_DATA   = q.hin_d;
	assign HIN_LAST   = q.hin_last;
	assign STX_VALID  = q.stx_v;
	assign STX_DATA   = q.stx_d;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	a_status_reserved: assert property (
		q.est == fsg_pkg::E_STAT0 |-> (HIN_DATA & 8'h5B) == 8'h00)
		else $error("reserved status bit set");
	a_length_byte: assert property (
		q.est == fsg_pkg::E_STAT0 && HIN_READY |=> HIN_DATA == $past(q.e_left))
		else $error("length byte mismatch");
	a_nd_toggles: assert property (
		$rose(HIN_VALID) && !q.mode_coll |-> q.nd != $past(q.nd))
		else $error("new-data flag did not invert");
	a_service_flag: assert property (
		q.sg_s2 || q.sd_s2 |=> q.svc)
		else $error("service flag not set");
	a_trunc_loss: assert property (
		q.est == fsg_pkg::E_IDLE && avail > {3'h0, q.hlen} && !q.mode_coll && q.cfg_done
		|=> q.dl && HIN_DATA[fsg_pkg::SB0_LOSS])
		else $error("truncation without data loss");
	a_cmd_no_fwd: assert property (
		HOUT_VALID && q.hout_rdy && q.h_idx == 2'h2 && q.h_ctrl0[0] && !q.hold_v
		|=> !q.hold_v)
		else $error("command data forwarded");
	a_start_char: assert property (
		q.tst == fsg_pkg::T_IDLE && q.hold_v |=> STX_VALID && STX_DATA == q.cfg.start)
		else $error("frame not opened by start byte");
	a_frame_count: assert property (
		q.tst == fsg_pkg::T_STOP2 && STX_READY
		|=> q.cnt[fsg_pkg::CNT_TXSER] == $past(q.cnt[fsg_pkg::CNT_TXSER]) + 16'h0001)
		else $error("sent frame not counted");
	a_ferr_count: assert property (
		SRX_VALID && SRX_FERR && q.cfg_done
		|=> q.cnt[fsg_pkg::CNT_FERR] == $past(q.cnt[fsg_pkg::CNT_FERR]) + 16'h0001)
		else $error("framing error not counted");

endmodule

`default_nettype wire

// file: testbench/fsg_partner.sv
/*
  Serial end device model for the gateway framer bench.
  Assumes the bench calls send_frame and reads sq hierarchically.
*/
`timescale 1ns/10ps
`default_nettype none

module fsg_partner (
	// Clock
	input  wire logic       REF_CLK,
	// Gateway transmit
	input  wire logic       STX_VALID,
	input  wire logic [7:0] STX_DATA,
	output var  logic       STX_READY,
	// Gateway receive
	output var  logic       SRX_VALID,
	output var  logic [7:0] SRX_DATA,
	output var  logic       SRX_FERR
);
	logic [7:0] sq[$];
	logic       slow = 1'b0;
	logic       ph = 1'b0;
	logic       stall = 1'b0;

	initial begin
		STX_READY = 1'b0;
		SRX_VALID = 1'b0;
		SRX_DATA = 8'h5A;
		SRX_FERR = 1'b0;
	end

	// Slow mode stalls the gateway on every other cycle; stall holds it off
	always @(posedge REF_CLK) begin
		ph <= ~ph;
		STX_READY <= stall ? 1'b0 : (slow ? ph : 1'b1);
		if (STX_VALID && STX_READY)
			sq.push_back(STX_DATA);
	end

	// Idle line shows the inverse, never a stale character
	task automatic put(input logic [7:0] b, input logic f);
		@(posedge REF_CLK);
		SRX_VALID <= 1'b1;
		SRX_DATA <= b;
		SRX_FERR <= f;
		@(posedge REF_CLK);
		SRX_VALID <= 1'b0;
		SRX_DATA <= ~b;
		SRX_FERR <= 1'b0;
	endtask

	// Frame wrapped in start and two stop characters
	task automatic send_frame(input logic [7:0] d[$], input int fe);
		put(8'h02, 1'b0);
		foreach (d[i])
			put(d[i], i == fe);
		put(8'h0D, 1'b0);
		put(8'h0A, 1'b0);
	endtask
endmodule

`default_nettype wire

// file: testbench/testbench.sv
/*
  Self-checking bench for the gateway framer.
  Assumes the partner model on the serial side and APB at 50 MHz.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic        REF_CLK = 1'b0, SRST = 1'b1;
	logic        PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic        PREADY, PSLVERR, GSP = 0, ESP = 0;
	logic        HOUT_VALID = 0, HOUT_LAST = 0, HOUT_READY;
	logic [7:0]  HOUT_DATA = 8'h00, HIN_DATA, STX_DATA, SRX_DATA;
	logic        HIN_VALID, HIN_LAST, HIN_READY = 0;
	logic        SRX_VALID, SRX_FERR, STX_VALID, STX_READY;
	logic [7:0]  hq[$];
	logic [3:0]  dss = 4'h8;
	logic [31:0] v;
	logic        e;
	int          errors = 0, tests_run = 0, hl = -1, cyc = 0;

	always #10 REF_CLK = ~REF_CLK;

	fsg_framer #(.TX_TIMEOUT(50)) dut (.REF_CLK(REF_CLK), .SRST(SRST),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.DEVICE_SELECT_SWITCH(dss), .GATEWAY_SERVICE_POSITION(GSP),
		.END_DEVICE_SERVICE_POSITION(ESP), .HOUT_VALID(HOUT_VALID),
		.HOUT_DATA(HOUT_DATA), .HOUT_LAST(HOUT_LAST), .HOUT_READY(HOUT_READY),
		.HIN_VALID(HIN_VALID), .HIN_DATA(HIN_DATA), .HIN_LAST(HIN_LAST),
		.HIN_READY(HIN_READY), .SRX_VALID(SRX_VALID), .SRX_DATA(SRX_DATA),
		.SRX_FERR(SRX_FERR), .STX_VALID(STX_VALID), .STX_DATA(STX_DATA),
		.STX_READY(STX_READY));

	fsg_partner p (.REF_CLK(REF_CLK), .STX_VALID(STX_VALID), .STX_DATA(STX_DATA),
		.STX_READY(STX_READY), .SRX_VALID(SRX_VALID), .SRX_DATA(SRX_DATA),
		.SRX_FERR(SRX_FERR));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [63:0] s, input logic [63:0] x);
		tests_run++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	// Size in the top byte, bytes in arrival order below
	function automatic logic [63:0] pk(input logic [7:0] q[$]);
		logic [55:0] r;
		r = '0;
		foreach (q[i])
			r = {r[47:0], q[i]};
		return {8'(q.size()), r};
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		v = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic hsend(input logic [7:0] b[$]);
		foreach (b[i]) begin
			HOUT_VALID <= 1'b1;
			HOUT_DATA <= b[i];
			HOUT_LAST <= i == b.size() - 1;
			do @(posedge REF_CLK); while (HOUT_READY !== 1'b1);
		end
		HOUT_VALID <= 1'b0;
	endtask

	task automatic hwait(input int n);
		for (int i = 0; i < 600 && hq.size() < n; i++)
			@(posedge REF_CLK);
	endtask

	always @(posedge REF_CLK) begin
		if (HIN_VALID === 1'b1 && HIN_READY) begin
			hq.push_back(HIN_DATA);
			if (HIN_LAST)
				hl = hq.size() - 1;
		end
	end

	// Run length cap, well above the sum of all scenarios
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		apb(0, 8'h0C, 0);
		chk(v, 32'h020D0A10);
		apb(0, 8'h08, 0);
		chk(v & 32'hF38, 32'h828);
		apb(1, 8'h00, 32'h1);
		apb(0, 8'h08, 0);
		chk(v[4], 1'b1);
		apb(1, 8'h00, 32'h0);
		apb(0, 8'h40, 0);
		chk(e, 1'b1);
		apb(1, 8'h08, 32'hFF);
		chk(e, 1'b1);
	endtask

	// Headers consumed, only framed data on the wire, stalling far side
	task automatic t_fwd();
		p.slow = 1'b1;
		hsend('{8'hFC, 8'hFF, 8'hA1, 8'hA2});
		for (int i = 0; i < 400 && p.sq.size() < 5; i++)
			@(posedge REF_CLK);
		chk(pk(p.sq), {8'd5, 16'h0, 40'h02A1A20D0A});
		apb(0, 8'h2C, 0);
		chk(v, 32'h1);
		p.slow = 1'b0;
	endtask

	task automatic t_trunc();
		apb(1, 8'h04, 32'h2);
		p.send_frame('{8'h11, 8'h22, 8'h33}, -1);
		hwait(4);
		chk(pk(hq), {8'd4, 24'h0, 32'hA0021122});
		chk(hl, 3);
		apb(0, 8'h08, 0);
		chk(v[1:0], 2'b11);
		hq.delete();
		GSP <= 1'b1;
		p.send_frame('{8'h44}, -1);
		hwait(3);
		chk(pk(hq), {8'd3, 32'h0, 24'h040144});
		GSP <= 1'b0;
		ESP <= 1'b1;
		repeat (8) @(posedge REF_CLK);
		apb(0, 8'h08, 0);
		chk(v[2], 1'b1);
		ESP <= 1'b0;
		repeat (8) @(posedge REF_CLK);
		apb(0, 8'h08, 0);
		chk(v[2], 1'b0);
	endtask

	task automatic t_cmd();
		p.sq.delete();
		hsend('{8'h01, 8'h00, 8'h43, 8'h46, 8'h55});
		repeat (60) @(posedge REF_CLK);
		chk(p.sq.size(), 0);
		apb(0, 8'h1C, 0);
		chk(v, 32'h1);
		apb(0, 8'h20, 0);
		chk(v, 32'h1);
		apb(0, 8'h24, 0);
		chk(v, 32'h1);
	endtask

	task automatic t_ferr();
		hq.delete();
		p.send_frame('{8'h66}, 0);
		repeat (20) @(posedge REF_CLK);
		chk(hq.size(), 0);
		apb(0, 8'h18, 0);
		chk(v, 32'h1);
		apb(0, 8'h14, 0);
		chk(v, 32'h2);
		apb(0, 8'h30, 0);
		chk(v, 32'h2);
	endtask

	// Stuck sink aborts the frame, rest of that telegram dropped, next one sent
	task automatic t_abort();
		p.stall = 1'b1;
		hsend('{8'h00, 8'h00, 8'hB1, 8'hB2});
		p.stall = 1'b0;
		@(posedge REF_CLK);
		hsend('{8'h00, 8'h00, 8'hC1});
		for (int i = 0; i < 100 && p.sq.size() < 4; i++)
			@(posedge REF_CLK);
		chk(pk(p.sq), {8'd4, 24'h0, 32'h02C10D0A});
		apb(0, 8'h28, 0);
		chk(v, 32'h1);
		apb(0, 8'h2C, 0);
		chk(v, 32'h2);
	endtask

	// Collective mode keeps the tail for a second telegram; fill seen while stalled
	task automatic t_coll();
		hq.delete();
		HIN_READY <= 1'b0;
		apb(1, 8'h00, 32'h1);
		p.send_frame('{8'h11, 8'h22, 8'h33}, -1);
		repeat (4) @(posedge REF_CLK);
		apb(0, 8'h10, 0);
		chk(v, 32'h3);
		HIN_READY <= 1'b1;
		hwait(7);
		chk(pk(hq), {8'd7, 56'h00021122000133});
		chk(hl, 6);
	endtask

	// Mid-run reset with an unsupported switch position
	task automatic t_reset();
		dss <= 4'hD;
		SRST <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		SRST <= 1'b0;
		while (HOUT_READY !== 1'b1)
			@(posedge REF_CLK);
		apb(0, 8'h08, 0);
		chk(v & 32'hF3B, 32'hD20);
		apb(0, 8'h0C, 0);
		chk(v, 32'h020D0A00);
		apb(0, 8'h04, 0);
		chk(v, 32'h8);
		apb(0, 8'h14, 0);
		chk(v, 32'h0);
	endtask

	initial begin
		repeat (4) @(posedge REF_CLK);
		SRST <= 1'b0;
		HIN_READY <= 1'b1;
		while (HOUT_READY !== 1'b1)
			@(posedge REF_CLK);
		apb(0, 8'h04, 0);
		chk(v, 32'h8);
		t_regs();
		t_fwd();
		t_trunc();
		t_cmd();
		t_ferr();
		t_abort();
		t_coll();
		t_reset();
		end_sim();
	end
endmodule

`default_nettype wire
